// File: inc/input_cond_pkg.sv
/*
 * Constants shared by the discrete input conditioning block: register
 * offsets, field layouts, reset values, filter delay table and timing.
 * Assumes a 20 MHz system clock and a 32-bit register port.
 */
package input_cond_pkg;

    localparam int          CLK_HZ         = 20_000_000;
    localparam int          MS_CYCLES      = CLK_HZ / 1000;
    localparam int          NUM_IN         = 8;
    localparam int          NUM_IN_ECO     = 4;
    localparam int          NUM_FAST_STD   = 2;

    // Shortest pulses the capture inputs must see, in ns
    localparam int          CATCH_FAST_NS  = 10_000;
    localparam int          CATCH_SLOW_NS  = 50_000;
    localparam int          CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;
    localparam int          CATCH_FAST_CYC = CATCH_FAST_NS / CLK_PERIOD_NS;
    localparam int          CATCH_SLOW_CYC = CATCH_SLOW_NS / CLK_PERIOD_NS;

    // Register offsets
    localparam logic [7:0]  OFS_FILTER     = 8'h00;
    localparam logic [7:0]  OFS_CATCH_EN   = 8'h04;
    localparam logic [7:0]  OFS_EDGE_CFG   = 8'h08;
    localparam logic [7:0]  OFS_PRIO       = 8'h0C;
    localparam logic [7:0]  OFS_IRQ_STAT   = 8'h10;
    localparam logic [7:0]  OFS_IRQ_MASK   = 8'h14;
    localparam logic [7:0]  OFS_IMAGE      = 8'h18;
    localparam logic [7:0]  OFS_LEVEL      = 8'h1C;
    localparam logic [7:0]  OFS_OTHER_IRQ  = 8'h20;
    localparam logic [7:0]  OFS_COUNTER_IN = 8'h24;

    // Field layout
    localparam int          FILT_CODE_W    = 4;
    localparam int          EDGE_W         = 2;
    localparam int          PRIO_W         = 4;
    localparam int          OTHER_W        = 4;
    localparam int          PEND_LSB       = 8;

    // Reset value and largest accepted filter code
    localparam logic [3:0]  FILT_CODE_RST  = 4'h4;
    localparam logic [3:0]  FILT_CODE_MAX  = 4'hA;

    // Trigger conditions
    typedef enum logic [1:0] {
        EDGE_OFF     = 2'h0,
        EDGE_RISE    = 2'h1,
        EDGE_FALL    = 2'h2,
        EDGE_BOTH    = 2'h3
    } edge_mode_t;

    // Filter delay in milliseconds for each selectable code
    function automatic int filt_ms(input logic [3:0] code);
        case (code)
            4'h0:    filt_ms = 0;
            4'h1:    filt_ms = 1;
            4'h2:    filt_ms = 2;
            4'h3:    filt_ms = 5;
            4'h4:    filt_ms = 10;
            4'h5:    filt_ms = 20;
            4'h6:    filt_ms = 50;
            4'h7:    filt_ms = 100;
            4'h8:    filt_ms = 200;
            4'h9:    filt_ms = 500;
            default: filt_ms = 1000;
        endcase
    endfunction

endpackage

// File: src/input_filter.sv
/*
 * One input lane: two-stage synchroniser and on/off delay filter.
 * Assumes the pin is asynchronous to clk and the delay is held stable
 * except across reconfiguration.
 */
module input_filter #(
    parameter int CNT_W = 25
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             pin,
    input  wire logic [CNT_W-1:0] delay_cyc,
    output logic                  sync_lvl,
    output logic                  filt_lvl
);

    logic             meta_reg;
    logic             sync_reg;
    logic             filt_reg;
    logic [CNT_W-1:0] cnt_reg;

    generate
        if (CNT_W < 2) begin : g_bad_width
            $error("input_filter: counter too narrow");
        end
    endgenerate

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
        end
    end

    // A change is taken only after it has held for the whole delay
    always_ff @(posedge clk) begin
        if (!rstn) begin
            filt_reg <= 1'b0;
            cnt_reg  <= '0;
        end else if (sync_reg == filt_reg) begin
            cnt_reg  <= '0;
        end else if (delay_cyc == '0 ||
                     cnt_reg + 1'b1 >= delay_cyc) begin
            filt_reg <= sync_reg;
            cnt_reg  <= '0;
        end else begin
            cnt_reg  <= cnt_reg + 1'b1;
        end
    end

    assign sync_lvl = sync_reg;
    assign filt_lvl = filt_reg;

endmodule // input_filter

// File: src/input_cond.sv
/*
 * Discrete input conditioning of the main unit: delay filter, pulse
 * catch into the scan image, and edge-triggered task requests with a
 * sticky status / mask interrupt.
 * Assumes one clock, a scan strobe from the CPU, a register port with
 * read data one cycle after the read strobe.
 */
// Strobed register access and the register offsets were decided locally.
module input_cond #(
    parameter bit ECONOMIC  = 1'b0,
    parameter int MS_CYCLES = input_cond_pkg::MS_CYCLES
) (
    input  wire logic                                  clk,
    input  wire logic                                  rstn,
    input  wire logic [input_cond_pkg::NUM_IN-1:0]     field_in,
    input  wire logic                                  scan_strobe,
    input  wire logic [7:0]                            addr,
    input  wire logic [31:0]                           wdata,
    input  wire logic                                  wr_strobe,
    input  wire logic                                  rd_strobe,
    output logic [31:0]                                rdata,
    output logic [input_cond_pkg::NUM_IN-1:0]          input_image,
    output logic                                       task_req,
    output logic [2:0]                                 task_sel,
    output logic [input_cond_pkg::PRIO_W-1:0]          task_prio,
    input  wire logic                                  task_ack,
    output logic                                       irq
);

    localparam int N      = input_cond_pkg::NUM_IN;
    localparam int PW     = input_cond_pkg::PRIO_W;
    localparam int CNT_W  = 25;
    localparam int N_USE  = ECONOMIC ? input_cond_pkg::NUM_IN_ECO : N;

    ////////////////////////////////////////////////////////////////////////

    generate
        if (MS_CYCLES < 1 || MS_CYCLES * 1000 >= (1 << CNT_W)) begin : g_bad
            $error("input_cond: MS_CYCLES out of range");
        end
        if (input_cond_pkg::CATCH_FAST_CYC < 1) begin : g_slow_clk
            $error("input_cond: clock too slow for pulse catch");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Registers written by software

    logic [3:0]       filt_code_reg;
    logic [N-1:0]     catch_en_reg;
    logic [2*N-1:0]   edge_cfg_reg;
    logic [PW*N-1:0]  prio_reg;
    logic [N-1:0]     irq_stat_reg;
    logic [N-1:0]     irq_mask_reg;
    logic [3:0]       other_irq_reg;
    logic [N-1:0]     counter_in_reg;

    logic             wr_filter;
    logic             wr_stat;

    assign wr_filter = wr_strobe && addr == input_cond_pkg::OFS_FILTER;
    assign wr_stat   = wr_strobe && addr == input_cond_pkg::OFS_IRQ_STAT;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            filt_code_reg <= input_cond_pkg::FILT_CODE_RST;
        end else if (wr_filter &&
                     wdata[3:0] <= input_cond_pkg::FILT_CODE_MAX) begin
            // Codes beyond the table are ignored, old delay kept
            filt_code_reg <= wdata[3:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            catch_en_reg   <= '0;
            edge_cfg_reg   <= '0;
            prio_reg       <= '0;
            irq_mask_reg   <= '0;
            other_irq_reg  <= '0;
            counter_in_reg <= '0;
        end else if (wr_strobe) begin
            unique case (addr)
                input_cond_pkg::OFS_CATCH_EN:   catch_en_reg   <= wdata[N-1:0];
                input_cond_pkg::OFS_EDGE_CFG:
                    edge_cfg_reg   <= wdata[2*N-1:0];
                input_cond_pkg::OFS_PRIO:
                    prio_reg       <= wdata[PW*N-1:0];
                input_cond_pkg::OFS_IRQ_MASK:   irq_mask_reg   <= wdata[N-1:0];
                input_cond_pkg::OFS_OTHER_IRQ:  other_irq_reg  <= wdata[3:0];
                input_cond_pkg::OFS_COUNTER_IN: counter_in_reg <= wdata[N-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Filter lanes, all sharing one delay

    logic [CNT_W-1:0] delay_cyc;
    logic [N-1:0]     sync_lvl;
    logic [N-1:0]     filt_lvl;

    assign delay_cyc = CNT_W'(input_cond_pkg::filt_ms(filt_code_reg)
                              * MS_CYCLES);

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_lane
            input_filter #(
                .CNT_W     (CNT_W)
            ) u_filter (
                .clk       (clk),
                .rstn      (rstn),
                .pin       (field_in[gi]),
                .delay_cyc (delay_cyc),
                .sync_lvl  (sync_lvl[gi]),
                .filt_lvl  (filt_lvl[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Edge detection on the synchronised samples

    logic [N-1:0] prev_reg;
    logic [N-1:0] rise;
    logic [N-1:0] fall;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= sync_lvl;
        end
    end

    assign rise = sync_lvl & ~prev_reg;
    assign fall = ~sync_lvl & prev_reg;

    ////////////////////////////////////////////////////////////////////////
    // Pulse catch into the scan image

    logic [N-1:0] catch_ok;
    logic [N-1:0] catch_reg;
    logic [N-1:0] image_reg;

    // Every pulse of at least one clock is seen, which covers both the
    // fast and the slow capture widths at this clock rate
    assign catch_ok = catch_en_reg & ~counter_in_reg
                      & N'((1 << N_USE) - 1);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            catch_reg <= '0;
        end else begin
            // A pulse arriving on the scan edge survives to the next scan
            catch_reg <= (catch_reg & ~{N{scan_strobe}})
                         | (rise & catch_ok);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            image_reg <= '0;
        end else if (scan_strobe) begin
            // Uncaught inputs simply follow the filtered level
            image_reg <= filt_lvl | (catch_reg & catch_ok);
        end
    end

    assign input_image = image_reg;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt input allocation

    logic [3:0]   avail;
    logic [N-1:0] int_ok;

    always_comb begin
        logic [3:0] seen;
        seen  = '0;
        avail = (other_irq_reg >= 4'(N_USE)) ? 4'h0
                : 4'(N_USE) - other_irq_reg;
        for (int i = 0; i < N; i++) begin
            int_ok[i] = 1'b0;
            if (edge_cfg_reg[2*i +: 2] != input_cond_pkg::EDGE_OFF &&
                !counter_in_reg[i] && i < N_USE) begin
                int_ok[i] = (seen < avail);
                seen      = seen + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge events per trigger condition

    logic [N-1:0] evt;

    always_comb begin
        for (int i = 0; i < N; i++) begin
            unique case (input_cond_pkg::edge_mode_t'(edge_cfg_reg[2*i +: 2]))
                input_cond_pkg::EDGE_OFF:  evt[i] = 1'b0;
                input_cond_pkg::EDGE_RISE: evt[i] = rise[i];
                input_cond_pkg::EDGE_FALL: evt[i] = !ECONOMIC && fall[i];
                input_cond_pkg::EDGE_BOTH: evt[i] = ECONOMIC ? rise[i]
                                               : rise[i] | fall[i];
            endcase
            evt[i] = evt[i] & int_ok[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pending task requests, presented by priority

    logic [N-1:0]  pend_reg;
    logic [N-1:0]  ack_clr;
    logic          best_vld;
    logic [2:0]    best_idx;
    logic [PW-1:0] best_prio;
    logic          req_reg;
    logic [2:0]    sel_reg;
    logic [PW-1:0] sel_prio_reg;

    // A lower number is the more urgent task; ties go to the lower input
    always_comb begin
        best_vld  = 1'b0;
        best_idx  = '0;
        best_prio = '1;
        for (int i = 0; i < N; i++) begin
            if (pend_reg[i] &&
                (!best_vld || prio_reg[PW*i +: PW] < best_prio)) begin
                best_vld  = 1'b1;
                best_idx  = 3'(i);
                best_prio = prio_reg[PW*i +: PW];
            end
        end
    end

    assign ack_clr = (task_ack && req_reg) ? N'(1) << sel_reg : '0;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pend_reg <= '0;
        end else begin
            // A new edge beats an acknowledge of the same input
            pend_reg <= (pend_reg & ~ack_clr) | evt;
        end
    end

    // Cleared in the ack cycle so an acknowledged request never repeats
    always_ff @(posedge clk) begin
        if (!rstn) begin
            req_reg      <= 1'b0;
            sel_reg      <= '0;
            sel_prio_reg <= '0;
        end else if (task_ack && req_reg) begin
            req_reg      <= 1'b0;
        end else begin
            req_reg      <= best_vld;
            sel_reg      <= best_idx;
            sel_prio_reg <= best_prio;
        end
    end

    assign task_req  = req_reg;
    assign task_sel  = sel_reg;
    assign task_prio = sel_prio_reg;

    ////////////////////////////////////////////////////////////////////////
    // Sticky status, write one to clear, set wins

    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~(wr_stat ? wdata[N-1:0] : '0))
                            | evt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irq_stat_reg | evt) & irq_mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port: data valid only in the cycle after the strobe

    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        unique case (addr)
            input_cond_pkg::OFS_FILTER:     rd_mux[3:0]      = filt_code_reg;
            input_cond_pkg::OFS_CATCH_EN:   rd_mux[N-1:0]    = catch_en_reg;
            input_cond_pkg::OFS_EDGE_CFG:   rd_mux[2*N-1:0]  = edge_cfg_reg;
            input_cond_pkg::OFS_PRIO:       rd_mux[PW*N-1:0] = prio_reg;
            input_cond_pkg::OFS_IRQ_STAT:   rd_mux[N-1:0]    = irq_stat_reg;
            input_cond_pkg::OFS_IRQ_MASK:   rd_mux[N-1:0]    = irq_mask_reg;
            input_cond_pkg::OFS_IMAGE:      rd_mux[N-1:0]    = image_reg;
            input_cond_pkg::OFS_LEVEL:      rd_mux[2*N-1:0]  = {pend_reg,
                                                                filt_lvl};
            input_cond_pkg::OFS_OTHER_IRQ:  rd_mux[3:0]      = other_irq_reg;
            input_cond_pkg::OFS_COUNTER_IN: rd_mux[N-1:0]    = counter_in_reg;
            default:                        rd_mux           = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata <= '0;
        end else begin
            rdata <= rd_strobe ? rd_mux : '0;
        end
    end

endmodule // input_cond

// File: verif/field_src.sv
/*
 * Field sensor model driving the eight raw discrete inputs.
 * Assumes the bench calls its tasks from a process tied to clk.
 */
module field_src (
    input  wire logic       clk,
    output logic [7:0]      field_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial field_in = 8'h00;

    task automatic set_lvl(input logic [7:0] v);
        @(posedge clk);
        field_in <= v;
    endtask

    // Flip lanes for n clocks then restore; contacts never bounce here,
    // so every edge the bench makes is one it can count
    task automatic pulse(input logic [7:0] m, input int n);
        logic [7:0] old;
        old = field_in;
        @(posedge clk);
        field_in <= old ^ m;
        repeat (n) @(posedge clk);
        field_in <= old;
    endtask
endmodule // field_src

// File: verif/input_cond_monitor.sv
/*
 * Checker on the ports of the input conditioning block.
 * Assumes one clock domain and the bench writing setup before use.
 */
module input_cond_monitor #(
    parameter bit ECONOMIC = 1'b0
) (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic [7:0]  field_in,
    input wire logic        scan_strobe,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr_strobe,
    input wire logic        rd_strobe,
    input wire logic [31:0] rdata,
    input wire logic [7:0]  input_image,
    input wire logic        task_req,
    input wire logic [2:0]  task_sel,
    input wire logic [3:0]  task_prio,
    input wire logic        task_ack,
    input wire logic        irq
);
    logic [15:0] edge_sh;
    logic [31:0] prio_sh;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Shadow of software setup, so outputs can be tied to it
    always_ff @(posedge clk) begin
        if (!rstn) begin
            edge_sh <= 16'h0000;
            prio_sh <= 32'h0000_0000;
        end else if (wr_strobe && addr == input_cond_pkg::OFS_EDGE_CFG) begin
            edge_sh <= wdata[15:0];
        end else if (wr_strobe && addr == input_cond_pkg::OFS_PRIO) begin
            prio_sh <= wdata;
        end
    end

    //////////////////////////////////////////////////////////////////
    sequence s_taken;
        task_req && task_ack;
    endsequence
    sequence s_waiting;
        task_req && !task_ack;
    endsequence

    a_image_held: assert property (
        !scan_strobe |=> $stable(input_image))
        else $error("image moved without a scan strobe");
    a_ack_drops: assert property (
        s_taken |=> !task_req)
        else $error("request stayed after acknowledge");
    a_req_holds: assert property (
        s_waiting |=> task_req)
        else $error("request withdrawn without acknowledge");
    a_eco_lanes: assert property (
        task_req |-> (!ECONOMIC || task_sel < 3'h4))
        else $error("request from a lane the variant lacks");
    a_cfg_live: assert property (
        task_req |-> edge_sh[{task_sel, 1'b0} +: 2] != 2'h0)
        else $error("request from a lane with trigger off");
    a_prio_match: assert property (
        task_req |-> task_prio == prio_sh[{task_sel, 2'h0} +: 4])
        else $error("priority differs from the lane setting");
    a_filter_read: assert property (
        rd_strobe && addr == input_cond_pkg::OFS_FILTER
        |=> rdata <= {28'h0, input_cond_pkg::FILT_CODE_MAX})
        else $error("filter code outside the table");
    a_reset_quiet: assert property (
        $rose(rstn) |-> !task_req && !irq && input_image == 8'h00)
        else $error("outputs not cleared by reset");
endmodule // input_cond_monitor

bind input_cond input_cond_monitor #(.ECONOMIC(ECONOMIC)) mon_u (
    .clk(clk), .rstn(rstn), .field_in(field_in),
    .scan_strobe(scan_strobe), .addr(addr), .wdata(wdata),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
    .input_image(input_image), .task_req(task_req),
    .task_sel(task_sel), .task_prio(task_prio),
    .task_ack(task_ack), .irq(irq));

// File: verif/input_pulse_filter_interrupt_tb_top.sv
/*
 * Self-checking bench for the input conditioning block.
 * Assumes 1 ms shortened to 4 clocks and the field model on the pins.
 */
module input_pulse_filter_interrupt_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        rstn;
    logic        scan_strobe;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr_strobe;
    logic        rd_strobe;
    logic        task_ack;
    logic [7:0]  field_in;
    logic [31:0] rdata;
    logic [7:0]  input_image;
    logic        task_req;
    logic [2:0]  task_sel;
    logic [3:0]  task_prio;
    logic        irq;
    int          n_mismatch = 0;
    int          samples_checked = 0;

    always #25 clk = ~clk;

    field_src field_u (.clk(clk), .field_in(field_in));

    input_cond #(.ECONOMIC(1'b0), .MS_CYCLES(4)) dut_u (
        .clk(clk), .rstn(rstn), .field_in(field_in),
        .scan_strobe(scan_strobe), .addr(addr), .wdata(wdata),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
        .input_image(input_image), .task_req(task_req),
        .task_sel(task_sel), .task_prio(task_prio),
        .task_ack(task_ack), .irq(irq));

    //////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_strobe <= 1'b1;
        @(posedge clk);
        wr_strobe <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clk);
        rd_strobe <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
    endtask

    task automatic scan;
        @(posedge clk);
        scan_strobe <= 1'b1;
        @(posedge clk);
        scan_strobe <= 1'b0;
        @(negedge clk);
    endtask

    // Wait for a request, judge it, take it, then see it leave
    task automatic take(input logic [2:0] s, input logic [3:0] p);
        for (int i = 0; i < 20 && task_req !== 1'b1; i++) @(negedge clk);
        chk(32'({task_req, task_sel, task_prio}), 32'({1'b1, s, p}));
        @(posedge clk);
        task_ack <= 1'b1;
        @(posedge clk);
        task_ack <= 1'b0;
        for (int i = 0; i < 4 && task_req !== 1'b0; i++) @(negedge clk);
    endtask

    //////////////////////////////////////////////////////////////////
    task automatic t_codes;
        rd_chk(input_cond_pkg::OFS_FILTER, 32'h4);
        for (int c = 0; c <= 11; c++) begin
            wr(input_cond_pkg::OFS_FILTER, 32'(c));
            rd_chk(input_cond_pkg::OFS_FILTER,
                   32'(c > 10 ? 10 : c));
        end
        wr(8'h30, 32'hFFFF_FFFF);
        rd_chk(8'h30, 32'h0);
    endtask

    // Code 2 is 8 clocks here: 6-clock changes must vanish
    task automatic t_filter;
        wr(input_cond_pkg::OFS_FILTER, 32'h2);
        field_u.pulse(8'hFF, 6);
        repeat (12) @(posedge clk);
        rd_chk(input_cond_pkg::OFS_LEVEL, 32'h0);
        field_u.set_lvl(8'hFF);
        repeat (14) @(posedge clk);
        rd_chk(input_cond_pkg::OFS_LEVEL, 32'hFF);
        field_u.pulse(8'hFF, 6);
        repeat (12) @(posedge clk);
        rd_chk(input_cond_pkg::OFS_LEVEL, 32'hFF);
        field_u.set_lvl(8'h00);
        repeat (14) @(posedge clk);
        rd_chk(input_cond_pkg::OFS_LEVEL, 32'h0);
    endtask

    task automatic t_catch;
        wr(input_cond_pkg::OFS_COUNTER_IN, 32'h0);
        wr(input_cond_pkg::OFS_CATCH_EN, 32'hFE);
        field_u.pulse(8'hFF, 1);
        repeat (6) @(posedge clk);
        scan();
        chk(32'(input_image), 32'hFE);
        scan();
        chk(32'(input_image), 32'h0);
        wr(input_cond_pkg::OFS_CATCH_EN, 32'h0);
    endtask

    // Lane 1 rise prio 3, lane 2 fall prio 1, lane 3 both prio 2
    task automatic t_edges;
        wr(input_cond_pkg::OFS_EDGE_CFG, 32'hE4);
        wr(input_cond_pkg::OFS_PRIO, 32'h2130);
        wr(input_cond_pkg::OFS_IRQ_MASK, 32'hFF);
        field_u.set_lvl(8'h0E);
        take(3'h3, 4'h2);
        take(3'h1, 4'h3);
        chk(32'(irq), 32'h1);
        rd_chk(input_cond_pkg::OFS_IRQ_STAT, 32'h0A);
        wr(input_cond_pkg::OFS_IRQ_STAT, 32'h0A);
        rd_chk(input_cond_pkg::OFS_IRQ_STAT, 32'h0);
        chk(32'(irq), 32'h0);
        field_u.set_lvl(8'h00);
        take(3'h2, 4'h1);
        take(3'h3, 4'h2);
        rd_chk(input_cond_pkg::OFS_IRQ_STAT, 32'h0C);
        wr(input_cond_pkg::OFS_IRQ_STAT, 32'hFF);
        wr(input_cond_pkg::OFS_IRQ_MASK, 32'h00);
        field_u.set_lvl(8'h02);
        take(3'h1, 4'h3);
        chk(32'(irq), 32'h0);
        rd_chk(input_cond_pkg::OFS_IRQ_STAT, 32'h02);
        wr(input_cond_pkg::OFS_IRQ_STAT, 32'hFF);
        field_u.set_lvl(8'h00);
    endtask

    // Seven other tasks in use leave only the first configured lane
    task automatic t_alloc;
        wr(input_cond_pkg::OFS_OTHER_IRQ, 32'h7);
        field_u.set_lvl(8'h0A);
        take(3'h1, 4'h3);
        rd_chk(input_cond_pkg::OFS_IRQ_STAT, 32'h02);
        wr(input_cond_pkg::OFS_OTHER_IRQ, 32'h0);
        field_u.set_lvl(8'h00);
        take(3'h3, 4'h2);
        wr(input_cond_pkg::OFS_IRQ_STAT, 32'hFF);
    endtask

    initial begin
        rstn        <= 1'b0;
        scan_strobe <= 1'b0;
        addr        <= 8'h00;
        wdata       <= 32'h0000_0000;
        wr_strobe   <= 1'b0;
        rd_strobe   <= 1'b0;
        task_ack    <= 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        t_codes();
        t_filter();
        t_catch();
        t_edges();
        t_alloc();
        close_out();
    end

    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        $display("watchdog expired");
        close_out();
    end
endmodule // input_pulse_filter_interrupt_tb_top
